// File: csr_pkg.sv
// Purpose: shared constants for the can slave command responder
// Assumes: 11-bit identifiers, classic frames of at most eight data bytes
// Notes:   byte 0 of a frame is the first byte on the wire
package csr_pkg;

  // identifier layout
  localparam int          ID_W          = 11;
  localparam int          FN_MSB        = 10;
  localparam int          FN_LSB        = 7;
  localparam int          NODE_MSB      = 6;
  localparam int          NODE_LSB      = 0;
  localparam logic [6:0]  NODE_BCAST    = 7'h00;
  localparam logic [6:0]  NODE_RESP     = 7'h7f;

  // function codes (normal response has bit 0 clear)
  // codes are the 4-bit field at id bits 10..7, so id 0x200 gives 4'h4
  localparam logic [3:0]  FN_READ       = 4'h4;
  localparam logic [3:0]  FN_WRITE_VOL  = 4'h8;
  localparam logic [3:0]  FN_WRITE_PERS = 4'hc;
  localparam logic [3:0]  FN_DIAG       = 4'he;
  localparam logic [3:0]  FN_EXC_BIT    = 4'h1;

  // status / error codes
  localparam logic [7:0]  ST_OK         = 8'h00;
  localparam logic [7:0]  ERR_FUNC      = 8'h01;
  localparam logic [7:0]  ERR_ADDR      = 8'h02;
  localparam logic [7:0]  ERR_FRAME     = 8'h03;
  localparam logic [7:0]  ERR_FAIL      = 8'h04;
  localparam logic [7:0]  ERR_RANGE     = 8'h05;
  localparam logic [7:0]  ERR_RO        = 8'h06;
  localparam logic [7:0]  ERR_RUNNING   = 8'h07;
  localparam logic [7:0]  ERR_PASSWORD  = 8'h08;

  // lengths
  localparam logic [3:0]  DLC_STATUS    = 4'h2;
  localparam logic [3:0]  DLC_DIAG_REQ  = 4'h2;
  localparam logic [3:0]  DLC_DIAG_RSP  = 4'h4;
  localparam logic [3:0]  DLC_PAIR      = 4'h4;
  localparam int          MAX_RD_REGS   = 3;
  localparam int          MAX_WR_PAIRS  = 2;

  // response buffer: word 0 holds node and status, then data words
  localparam int          RSP_WORDS     = 4;

endpackage : csr_pkg

// File: csr_word_mem.sv
// Purpose: small response word store with registered read data
// Assumes: one write port and one read port on the same clock
// Notes:   contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none

module csr_word_mem #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic                 core_clk,
  input  wire logic                 we,
  input  wire logic [$clog2(D)-1:0] waddr,
  input  wire logic [W-1:0]         wdata,
  input  wire logic [$clog2(D)-1:0] raddr,
  output logic      [W-1:0]         rdata
);

  logic [W-1:0] mem [D];

  if (D < 2 || W < 1) begin : g_bad_geometry
    $error("csr_word_mem: bad geometry");
  end

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata <= mem[raddr];
  end

endmodule : csr_word_mem

`default_nettype wire

// File: csr_responder.sv
// Purpose: decodes register-access request frames and builds response frames
// Assumes: parameter store outside answers each access with an ack and fault flags
// Notes:   one request in flight; rx_ready is low from acceptance until the answer leaves
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - node field zero is a broadcast that this slave accepts.
// - broadcasts are executed but never answered.
// - executable request gets a normal response.
// - unexecutable request gets an exception response with the cause.
// - normal response repeats function code with bit 0 cleared.
// - exception response sets function code bit 0.
// - status byte 00 on success, nonzero error code otherwise.
// - unsupported function code gives error 01.
// - bad address, or start plus length invalid, gives error 02.
// - data length wrong for the function gives error 03.
// - unrecoverable fault during execution gives error 04.
// - written value outside register limits gives error 05.
// - write to read-only register gives 06 and changes nothing.
// - write to stop-only register while running gives 07.
// - password-protected register gives 08.
// - control word write 1 runs forward, 0 stops, length four.
// - response identifier node field is 7F, status responses length two.
// - register 0007 sets running frequency in hundredths of a hertz.
// - read lists addresses, answer carries node, status, values high first.
// - two-byte diagnostic is echoed with length four.
// - function c writes persistently, function 8 writes volatile.
// - a write carries at most two pairs, length four per pair.
module csr_responder
  import csr_pkg::*;
#(
  parameter int RD_REGS  = MAX_RD_REGS,
  parameter int WR_PAIRS = MAX_WR_PAIRS
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [6:0]        node_addr,
  input  wire logic              drive_running,
  input  wire logic              rx_valid,
  output logic                   rx_ready,
  input  wire logic [ID_W-1:0]   rx_id,
  input  wire logic [3:0]        rx_dlc,
  input  wire logic [63:0]       rx_data,
  output logic                   par_req,
  output logic                   par_write,
  output logic                   par_persist,
  output logic [15:0]            par_addr,
  output logic [15:0]            par_wdata,
  input  wire logic              par_ack,
  input  wire logic [15:0]       par_rdata,
  input  wire logic              par_bad_addr,
  input  wire logic              par_read_only,
  input  wire logic              par_run_locked,
  input  wire logic              par_password,
  input  wire logic              par_out_of_range,
  input  wire logic              par_fail,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [ID_W-1:0]        tx_id,
  output logic [3:0]             tx_dlc,
  output logic [63:0]            tx_data
);

  if (RD_REGS < 1 || RD_REGS > MAX_RD_REGS || WR_PAIRS < 1 || WR_PAIRS > MAX_WR_PAIRS) begin : g_bad_params
    $error("csr_responder: RD_REGS or WR_PAIRS out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_ACCESS, S_WAIT, S_FINISH, S_LOAD, S_SEND
  } csr_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // 16-bit word starting at byte k, first byte is the high byte
  function automatic logic [15:0] csr_word_at(input logic [63:0] d, input logic [2:0] k);
    logic [5:0] sh;
    sh = 6'(7 - int'(k)) * 6'd8;
    return {8'((d >> sh)), 8'((d >> (sh - 6'd8)))};
  endfunction : csr_word_at

  function automatic logic csr_fn_supported(input logic [3:0] fn);
    return fn == FN_READ || fn == FN_WRITE_VOL || fn == FN_WRITE_PERS || fn == FN_DIAG;
  endfunction : csr_fn_supported

  // store fault flags to error code, first match wins
  function automatic logic [7:0] csr_fault_code(input logic wr, input logic running,
                                                input logic bad, input logic ro, input logic rl,
                                                input logic pw, input logic rng, input logic fl);
    if (bad)                  return ERR_ADDR;
    else if (pw)              return ERR_PASSWORD;
    else if (wr && ro)        return ERR_RO;
    else if (wr && rl && running) return ERR_RUNNING;
    else if (wr && rng)       return ERR_RANGE;
    else if (fl)              return ERR_FAIL;
    else                      return ST_OK;
  endfunction : csr_fault_code

  ////////////////////////////////////////////////////////////////////////////
  // request capture

  csr_state_e  state;
  logic [3:0]  fn;
  logic        bcast;
  logic [3:0]  dlc;
  logic [63:0] req_data;
  logic [7:0]  status;
  logic [1:0]  idx;
  logic [1:0]  n_items;
  logic [2:0]  rd_cnt;
  logic [2:0]  n_words;
  logic [7:0]  next_status;

  logic        accept;
  logic        for_us;
  logic        is_write;
  logic        ack_ok;
  logic [7:0]  fault;

  assign rx_ready = (state == S_IDLE);
  assign for_us   = rx_id[NODE_MSB:NODE_LSB] == node_addr
                    || rx_id[NODE_MSB:NODE_LSB] == NODE_BCAST;
  assign accept   = rx_valid && rx_ready && for_us;
  assign is_write = fn == FN_WRITE_VOL || fn == FN_WRITE_PERS;
  assign fault    = csr_fault_code(is_write, drive_running, par_bad_addr, par_read_only,
                                   par_run_locked, par_password, par_out_of_range, par_fail);
  assign ack_ok   = par_ack && fault == ST_OK;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fn       <= 4'h0;
      bcast    <= 1'b0;
      dlc      <= 4'h0;
      req_data <= 64'h0;
    end else if (accept) begin
      fn       <= rx_id[FN_MSB:FN_LSB];
      bcast    <= rx_id[NODE_MSB:NODE_LSB] == NODE_BCAST;
      dlc      <= rx_dlc;
      req_data <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // length and function checks

  always_comb begin
    next_status = ST_OK;
    if (!csr_fn_supported(fn)) begin
      next_status = ERR_FUNC;
    end else if (fn == FN_DIAG) begin
      if (dlc != DLC_DIAG_REQ) next_status = ERR_FRAME;
    end else if (fn == FN_READ) begin
      if (dlc == 4'h0 || dlc[0]) next_status = ERR_FRAME;
      else if (int'(dlc) > 2 * RD_REGS) next_status = ERR_ADDR;
    end else begin
      if (dlc == 4'h0 || dlc[1:0] != 2'b00 || int'(dlc) > int'(DLC_PAIR) * WR_PAIRS) begin
        next_status = ERR_FRAME;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= S_IDLE;
      status  <= ST_OK;
      idx     <= 2'd0;
      n_items <= 2'd0;
      rd_cnt  <= 3'd0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (accept) state <= S_CHECK;
        end
        S_CHECK: begin
          status <= next_status;
          idx    <= 2'd0;
          n_items <= (fn == FN_READ) ? 2'(dlc >> 1) : 2'(dlc >> 2);
          if (next_status != ST_OK || fn == FN_DIAG) state <= S_FINISH;
          else state <= S_ACCESS;
        end
        S_ACCESS: begin
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (par_ack) begin
            if (fault != ST_OK) begin
              status <= fault;
              state  <= S_FINISH;
            end else if (idx + 2'd1 == n_items) begin
              state <= S_FINISH;
            end else begin
              idx   <= idx + 2'd1;
              state <= S_ACCESS;
            end
          end
        end
        S_FINISH: begin
          rd_cnt <= 3'd0;
          if (bcast) state <= S_IDLE;
          else state <= S_LOAD;
        end
        S_LOAD: begin
          rd_cnt <= rd_cnt + 3'd1;
          if (rd_cnt == 3'(RSP_WORDS)) state <= S_SEND;
        end
        S_SEND: begin
          if (tx_ready) state <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter store access

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_req     <= 1'b0;
      par_write   <= 1'b0;
      par_persist <= 1'b0;
      par_addr    <= 16'h0000;
      par_wdata   <= 16'h0000;
    end else if (state == S_ACCESS) begin
      par_req     <= 1'b1;
      par_write   <= is_write;
      par_persist <= fn == FN_WRITE_PERS;
      if (fn == FN_READ) begin
        par_addr  <= csr_word_at(req_data, {idx, 1'b0});
        par_wdata <= 16'h0000;
      end else begin
        // control word, frequency and other targets are all routed to the store
        par_addr  <= csr_word_at(req_data, {idx[0], 2'b00});
        par_wdata <= csr_word_at(req_data, {idx[0], 2'b10});
      end
    end else if (par_ack) begin
      par_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response buffer

  logic                          mem_we;
  logic [$clog2(RSP_WORDS)-1:0]  mem_waddr;
  logic [15:0]                   mem_wdata;
  logic [15:0]                   mem_rdata;

  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = 16'h0000;
    if (state == S_CHECK && fn == FN_DIAG) begin
      mem_we    = 1'b1;
      mem_waddr = 2'd1;
      mem_wdata = csr_word_at(req_data, 3'd0);
    end else if (state == S_WAIT && ack_ok && fn == FN_READ) begin
      mem_we    = 1'b1;
      mem_waddr = 2'(idx + 2'd1);
      mem_wdata = par_rdata;
    end else if (state == S_FINISH) begin
      mem_we    = 1'b1;
      mem_waddr = 2'd0;
      mem_wdata = {1'b0, node_addr, status};
    end
  end

  csr_word_mem #(
    .W (16),
    .D (RSP_WORDS)
  ) u_mem (
    .core_clk (core_clk),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (2'(rd_cnt)),
    .rdata    (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // response frame

  assign tx_valid = (state == S_SEND);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_id   <= '0;
      tx_dlc  <= 4'h0;
      n_words <= 3'd0;
    end else if (state == S_FINISH) begin
      if (status != ST_OK) begin
        tx_id   <= {fn | FN_EXC_BIT, NODE_RESP};
        tx_dlc  <= DLC_STATUS;
        n_words <= 3'd1;
      end else begin
        tx_id   <= {fn & ~FN_EXC_BIT, NODE_RESP};
        if (fn == FN_READ) begin
          tx_dlc  <= DLC_STATUS + {n_items, 1'b0};
          n_words <= 3'(n_items) + 3'd1;
        end else if (fn == FN_DIAG) begin
          tx_dlc  <= DLC_DIAG_RSP;
          n_words <= 3'd2;
        end else begin
          tx_dlc  <= DLC_STATUS;
          n_words <= 3'd1;
        end
      end
    end
  end

  // word j of the buffer lands in bytes 2j and 2j+1; unused bytes stay zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_data <= 64'h0;
    end else if (state == S_FINISH) begin
      tx_data <= 64'h0;
    end else if (state == S_LOAD && rd_cnt != 3'd0 && (rd_cnt - 3'd1) < n_words) begin
      tx_data[63 - 16 * (int'(rd_cnt) - 1) -: 16] <= mem_rdata;
    end
  end

endmodule : csr_responder

`default_nettype wire

// File: csr_store_model.sv
// Purpose: parameter store on the far side of csr_responder
// Assumes: one access at a time, answer after lat idle cycles
// Notes:   fault bits {bad, ro, run, pw, range, fail} come from the bench
`timescale 1ns/1ps
`default_nettype none
module csr_store_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        par_req,
  input  wire logic        par_write,
  input  wire logic        par_persist,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  input  wire logic [1:0]  lat,
  input  wire logic [5:0]  fault,
  output logic             par_ack,
  output logic [15:0]      par_rdata,
  output logic             par_bad_addr,
  output logic             par_read_only,
  output logic             par_run_locked,
  output logic             par_password,
  output logic             par_out_of_range,
  output logic             par_fail,
  output logic             drive_running,
  output logic [3:0]       pers_cnt
);
  logic [15:0] mem [16];
  logic [1:0]  wait_cnt;
  logic [15:0] rd;
  // outside the ack the lines carry the inverse, never a stale answer
  assign rd        = mem[par_addr[3:0]];
  assign par_rdata = par_ack ? rd : ~rd;
  assign {par_bad_addr, par_read_only, par_run_locked, par_password, par_out_of_range, par_fail} =
    par_ack ? fault : ~fault;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      par_ack       <= 1'b0;
      wait_cnt      <= 2'h0;
      drive_running <= 1'b0;
      pers_cnt      <= 4'h0;
      for (int i = 0; i < 16; i++) mem[i] <= 16'h0000;
    end else begin
      par_ack <= 1'b0;
      if (!par_req || par_ack) begin
        wait_cnt <= 2'h0;
      end else if (wait_cnt == lat) begin
        par_ack <= 1'b1;
        // a flagged write is never committed
        if (par_write && fault == 6'h00) begin
          mem[par_addr[3:0]] <= par_wdata;
          if (par_addr == 16'h7000) drive_running <= (par_wdata == 16'h0001);
          if (par_persist) pers_cnt <= pers_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : csr_store_model
`default_nettype wire

// File: csr_responder_chk.sv
// Purpose: port assertions for csr_responder
// Assumes: length and function errors answer 8 cycles after take
// Notes:   function field is id bits 10..7 (read 4, write 8, persist c, diag e)
`timescale 1ns/1ps
`default_nettype none
module csr_responder_chk
  import csr_pkg::*;
#(
  parameter int RD_REGS  = MAX_RD_REGS,
  parameter int WR_PAIRS = MAX_WR_PAIRS
) (
  input wire logic            core_clk,
  input wire logic            rst_b,
  input wire logic [6:0]      node_addr,
  input wire logic            drive_running,
  input wire logic            rx_valid,
  input wire logic            rx_ready,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic [3:0]      rx_dlc,
  input wire logic [63:0]     rx_data,
  input wire logic            par_req,
  input wire logic            par_write,
  input wire logic            par_persist,
  input wire logic [15:0]     par_addr,
  input wire logic [15:0]     par_wdata,
  input wire logic            par_ack,
  input wire logic [15:0]     par_rdata,
  input wire logic            par_bad_addr,
  input wire logic            par_read_only,
  input wire logic            par_run_locked,
  input wire logic            par_password,
  input wire logic            par_out_of_range,
  input wire logic            par_fail,
  input wire logic            tx_valid,
  input wire logic            tx_ready,
  input wire logic [ID_W-1:0] tx_id,
  input wire logic [3:0]      tx_dlc,
  input wire logic [63:0]     tx_data
);
  logic       own_take;
  logic       bc_take;
  logic       in_bc;
  logic [3:0] fn;
  assign fn       = rx_id[FN_MSB:FN_LSB];
  assign own_take = rx_valid && rx_ready && rx_id[6:0] == node_addr;
  assign bc_take  = rx_valid && rx_ready && rx_id[6:0] == NODE_BCAST;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // high from a broadcast take until the block is idle again
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) in_bc <= 1'b0;
    else if (bc_take) in_bc <= 1'b1;
    else if (rx_ready) in_bc <= 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_bcast_silent: assert property (tx_valid |-> !in_bc)
    else $error("response frame sent for a broadcast");
  a_bcast_exec: assert property (bc_take && fn == 4'h8 && rx_dlc == DLC_PAIR
    |-> ##3 par_req && par_addr == $past(rx_data[63:48], 3)) else $error("broadcast write not executed");
  a_fn_lsb: assert property (tx_valid |-> tx_id[7] == (tx_data[55:48] != ST_OK))
    else $error("function bit 0 disagrees with status");
  a_resp_node: assert property (tx_valid |-> tx_id[6:0] == NODE_RESP && tx_data[63:56] == {1'b0, node_addr})
    else $error("response id or node byte wrong");
  a_err_frame: assert property (tx_valid && tx_data[55:48] != ST_OK
    |-> tx_dlc == DLC_STATUS && tx_data[47:0] == 48'h0) else $error("exception frame layout wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_id) && $stable(tx_dlc) && $stable(tx_data)) else $error("response changed early");
  a_busy_refuse: assert property (own_take |=> !rx_ready [*2])
    else $error("ready while busy");
  a_diag_echo: assert property (own_take && fn == 4'he && rx_dlc == DLC_DIAG_REQ |-> ##8 tx_valid
    && tx_id == 11'h77f && tx_dlc == DLC_DIAG_RSP && tx_data[47:32] == $past(rx_data[63:48], 8))
    else $error("diagnostic echo wrong");
  a_bad_func: assert property (own_take && !(fn inside {4'h4, 4'h8, 4'hc, 4'he}) |-> ##8 tx_valid
    && tx_data[55:48] == ERR_FUNC && tx_id == {$past(fn, 8) | 4'h1, NODE_RESP}) else $error("bad function answer");
  a_bad_len: assert property (own_take && fn == 4'h8 && rx_dlc != 4'h4 && rx_dlc != 4'h8
    |-> ##8 tx_valid && tx_data[55:48] == ERR_FRAME && tx_id == 11'h4ff) else $error("bad length answer");
endmodule : csr_responder_chk
bind csr_responder csr_responder_chk #(.RD_REGS(RD_REGS), .WR_PAIRS(WR_PAIRS)) u_chk (.*);
`default_nettype wire

// File: csr_responder_tb.sv
// Purpose: self-checking bench for csr_responder
// Assumes: node address 1, store answers after 0 to 2 cycles
// Notes:   table rows first, then broadcast, foreign node and reset cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module csr_responder_tb;
  typedef struct {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] d;
    logic [5:0]  flt;
    logic [10:0] eid;
    logic [3:0]  edlc;
    logic [63:0] ed;
  } csr_row_s;
  logic        core_clk, rst_b, drive_running, rx_valid, rx_ready, par_req, par_write, par_persist, par_ack;
  logic        par_bad_addr, par_read_only, par_run_locked, par_password, par_out_of_range, par_fail;
  logic        tx_valid, tx_ready;
  logic [6:0]  node_addr;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_dlc, tx_dlc, pers_cnt;
  logic [63:0] rx_data, tx_data;
  logic [15:0] par_addr, par_wdata, par_rdata;
  logic [1:0]  lat;
  logic [5:0]  fault;
  int          err_total = 0;
  int          checks = 0;
  csr_row_s    rows [16] = '{
    '{11'h701, 4'h2, 64'h55aa000000000000, 6'h00, 11'h77f, 4'h4, 64'h010055aa00000000},
    '{11'h401, 4'h4, 64'h7000000100000000, 6'h00, 11'h47f, 4'h2, 64'h0100000000000000},
    '{11'h401, 4'h4, 64'h0007138800000000, 6'h00, 11'h47f, 4'h2, 64'h0100000000000000},
    '{11'h401, 4'h4, 64'h7000000000000000, 6'h10, 11'h4ff, 4'h2, 64'h0106000000000000},
    '{11'h201, 4'h4, 64'h7000000700000000, 6'h00, 11'h27f, 4'h6, 64'h0100000113880000},
    '{11'h601, 4'h4, 64'h0023002800000000, 6'h00, 11'h67f, 4'h2, 64'h0100000000000000},
    '{11'h301, 4'h2, 64'h0000000000000000, 6'h00, 11'h3ff, 4'h2, 64'h0101000000000000},
    '{11'h401, 4'h3, 64'h0000000000000000, 6'h00, 11'h4ff, 4'h2, 64'h0103000000000000},
    '{11'h201, 4'h8, 64'h0000000000000000, 6'h00, 11'h2ff, 4'h2, 64'h0102000000000000},
    '{11'h201, 4'h2, 64'h0023000000000000, 6'h04, 11'h2ff, 4'h2, 64'h0108000000000000},
    '{11'h401, 4'h4, 64'h0007000100000000, 6'h08, 11'h4ff, 4'h2, 64'h0107000000000000},
    '{11'h601, 4'h4, 64'h0007ffff00000000, 6'h02, 11'h6ff, 4'h2, 64'h0105000000000000},
    '{11'h601, 4'h4, 64'h0007000100000000, 6'h01, 11'h6ff, 4'h2, 64'h0104000000000000},
    '{11'h201, 4'h2, 64'h0050000000000000, 6'h20, 11'h2ff, 4'h2, 64'h0102000000000000},
    '{11'h401, 4'h8, 64'h7000000000070fa0, 6'h00, 11'h47f, 4'h2, 64'h0100000000000000},
    '{11'h201, 4'h6, 64'h7000000700230000, 6'h00, 11'h27f, 4'h8, 64'h010000000fa00028}};
  csr_responder #(.RD_REGS(3), .WR_PAIRS(2)) DUT (.*);
  csr_store_model u_store (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish
  // entered at a falling edge; released lines show the inverse
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    {rx_id, rx_dlc, rx_data, rx_valid} = {id, dlc, d, 1'b1};
    while (rx_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    {rx_id, rx_dlc, rx_data, rx_valid} = {~id, ~dlc, ~d, 1'b0};
  endtask : send
  // the far side stalls two cycles before taking the answer
  task automatic expect_rsp(input logic [10:0] eid, input logic [3:0] edlc, input logic [63:0] ed);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    `CHK({tx_valid, tx_id, tx_dlc, tx_data}, {1'b1, eid, edlc, ed})
    repeat (2) @(negedge core_clk);
    tx_ready = 1'b1;
    @(negedge core_clk);
    tx_ready = 1'b0;
  endtask : expect_rsp
  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge core_clk);
      if (tx_valid !== 1'b0) seen = 1'b1;
    end
    `CHK({seen, rx_ready}, 2'h1)
  endtask : quiet
  initial begin
    int cyc;
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 3000) begin
        err_total++;
        tally_and_finish();
      end
    end
  end
  initial begin
    {rst_b, rx_valid, rx_id, rx_dlc, rx_data, tx_ready, lat, fault} = '0;
    node_addr = 7'h01;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    `CHK({rx_ready, tx_valid, par_req, tx_id}, 14'h2000)
    for (int i = 0; i < 16; i++) begin
      lat = 2'(i % 3);
      fault = rows[i].flt;
      send(rows[i].id, rows[i].dlc, rows[i].d);
      expect_rsp(rows[i].eid, rows[i].edlc, rows[i].ed);
    end
    `CHK({drive_running, pers_cnt}, 5'h01)
    fault = 6'h00;
    send(11'h400, 4'h4, 64'h0007123400000000);
    quiet(40);
    send(11'h201, 4'h2, 64'h0007000000000000);
    expect_rsp(11'h27f, 4'h4, 64'h0100123400000000);
    send(11'h402, 4'h4, 64'h0007555500000000);
    quiet(20);
    // reset in mid-frame: the block must come back idle and answer again
    send(11'h701, 4'h2, 64'h1234000000000000);
    repeat (3) @(negedge core_clk);
    rst_b = 1'b0;
    @(negedge core_clk);
    rst_b = 1'b1;
    `CHK({rx_ready, tx_valid, par_req, tx_id}, 14'h2000)
    send(11'h701, 4'h2, 64'h1234000000000000);
    expect_rsp(11'h77f, 4'h4, 64'h0100123400000000);
    tally_and_finish();
  end
endmodule : csr_responder_tb
`default_nettype wire
